// ===== hw/crr_exec_core.v
// call, return and rotate execution slice with apb register access
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "crr_exec_consts.vh"
// Summary of operation
// - push stores pc plus 2 onto the stack top in quarter two.
// - relative call opcode is 11011 plus signed 11-bit offset.
// - relative call pushes pc plus 2, then jumps to pc+2+2n.
// - relative call lasts two cycles; second idle, no flags change.
// - software reset restores the registers of arch_clear to reset values from quarter two; opcode, op_addr and operand keep theirs.
// - interrupt return pops pc in quarter four, sets an irq enable, two cycles.
// - with s set, both returns restore accumulator, flags, bank from shadows.
// - subroutine return pops pc in quarter four, two cycles, no flags unless s set.
// - literal return loads accumulator and pops pc; latches unchanged.
// - rotate left through carry updates carry, negative and zero.
// - rotate left without carry wraps bit 7, changes negative and zero.
// - rotate right through carry updates carry, negative and zero.
// - destination bit zero writes accumulator, one writes the result back to dmem at op_addr.
// - access bit zero uses access bank, one uses bank select.
// - extended mode with a zero maps addresses up to 95 indexed.
module crr_exec_core (
  input wire ref_clk_in,
  input wire sys_rst_in,
  input wire apb_psel_in,
  input wire apb_penable_in,
  input wire apb_pwrite_in,
  input wire [11:0] apb_paddr_in,
  input wire [31:0] apb_pwdata_in,
  output reg [31:0] apb_prdata_out,
  output reg apb_pready_out,
  output reg apb_pslverr_out
);
  localparam ST_IDLE = 3'b001;
  localparam ST_EXEC = 3'b010;
  localparam ST_WAIT = 3'b100;

  reg [2:0] state;
  reg [1:0] quarter;
  reg [15:0] opcode;
  reg [20:0] pc;
  reg [7:0] acc;
  reg [7:0] flags;
  reg [3:0] bank;
  reg [7:0] acc_shadow;
  reg [7:0] flags_shadow;
  reg [3:0] bank_shadow;
  reg ext_en;
  reg gie_high;
  reg gie_low;
  reg [7:0] latch_upper;
  reg [7:0] latch_high;
  reg [11:0] index_base;
  reg [11:0] mem_addr;
  reg [11:0] op_addr;
  reg [7:0] operand;
  reg [7:0] rot_res;
  reg rot_carry;
  reg [4:0] sp;
  reg [20:0] stack [0:30];
  reg [7:0] dmem [0:4095];
  reg [31:0] next_rdata;
  reg next_err;

  wire q1 = (state == ST_EXEC) && (quarter == 2'h1);
  wire q3 = (state == ST_EXEC) && (quarter == `CRR_Q_LAST);
  wire is_push = (opcode == `CRR_OP_PUSH);
  wire is_swrst = (opcode == `CRR_OP_SWRST);
  wire is_reti = (opcode[15:1] == `CRR_OP_RETI);
  wire is_ret = (opcode[15:1] == `CRR_OP_RET);
  wire is_return_with_literal = (opcode[15:8] == `CRR_OP_RETURN_WITH_LITERAL);
  wire is_relative_call = (opcode[15:11] == `CRR_OP_RELATIVE_CALL);
  wire is_rlc = (opcode[15:10] == `CRR_OP_RLC);
  wire is_rlnc = (opcode[15:10] == `CRR_OP_RLNC);
  wire is_rrc = (opcode[15:10] == `CRR_OP_RRC);
  wire is_rot = is_rlc | is_rlnc | is_rrc;
  wire is_pop = is_reti | is_ret | is_return_with_literal;
  wire two_cycle = is_relative_call | is_pop;
  wire push_now = q1 && (is_push || is_relative_call) && (sp != `CRR_STK_FULL);
  wire [20:0] stack_top = (sp == 5'h0) ? `CRR_RST_PC : stack[sp - 5'h1];
  wire [20:0] pc_next = pc + `CRR_PC_STEP;
  wire [20:0] call_target = pc_next + {{9{opcode[10]}}, opcode[10:0], 1'b0};
  wire idle = (state == ST_IDLE);
  wire wr_fire = apb_psel_in && apb_penable_in && apb_pwrite_in && apb_pready_out;

  // operand address from access bit, bank and extended mode
  function [11:0] eff_addr;
    input [7:0] f;
    input use_bank;
    input [3:0] bk;
    input ext;
    input [11:0] base;
    begin
      if (use_bank)
        eff_addr = {bk, f};
      else if (ext && (f <= `CRR_LIT_MAX))
        eff_addr = base + {4'h0, f};
      else if (f < `CRR_ACC_SPLIT)
        eff_addr = {4'h0, f};
      else
        eff_addr = {4'hF, f};
    end
  endfunction

  // first access cycle of an apb transfer
  function access_first;
    input sel;
    input en;
    input rdy;
    begin
      access_first = sel && en && !rdy;
    end
  endfunction

  wire acc_first = access_first(apb_psel_in, apb_penable_in, apb_pready_out);

  // reset values shared by pin reset and software reset
  task arch_clear;
    begin
      pc <= `CRR_RST_PC;
      acc <= `CRR_RST_BYTE;
      flags <= `CRR_RST_BYTE;
      bank <= `CRR_RST_BANK;
      acc_shadow <= `CRR_RST_BYTE;
      flags_shadow <= `CRR_RST_BYTE;
      bank_shadow <= `CRR_RST_BANK;
      ext_en <= 1'b0;
      gie_high <= 1'b0;
      gie_low <= 1'b0;
      latch_upper <= `CRR_RST_BYTE;
      latch_high <= `CRR_RST_BYTE;
      index_base <= `CRR_RST_ADDR;
      mem_addr <= `CRR_RST_ADDR;
      sp <= 5'h0;
    end
  endtask

  // return stack storage
  always @(posedge ref_clk_in)
  begin
    if (push_now)
      stack[sp] <= pc_next;
  end

  // data memory, rotate write-back wins over bus
  always @(posedge ref_clk_in)
  begin
    if (q3 && is_rot && opcode[`CRR_BIT_D])
      dmem[op_addr] <= rot_res;
    else if (idle && wr_fire && (apb_paddr_in == `CRR_OFF_MDATA))
      dmem[mem_addr] <= apb_pwdata_in[7:0];
  end

  // rotate datapath
  always @*
  begin
    rot_res = operand;
    rot_carry = flags[`CRR_FLG_C];
    if (is_rlc)
    begin
      rot_res = {operand[6:0], flags[`CRR_FLG_C]};
      rot_carry = operand[7];
    end
    else if (is_rlnc)
      rot_res = {operand[6:0], operand[7]};
    else if (is_rrc)
    begin
      rot_res = {flags[`CRR_FLG_C], operand[7:1]};
      rot_carry = operand[0];
    end
  end

  // sequencer and architectural registers
  always @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      arch_clear;
      state <= ST_IDLE;
      quarter <= 2'h0;
      opcode <= 16'h0000;
      op_addr <= `CRR_RST_ADDR;
      operand <= `CRR_RST_BYTE;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          quarter <= 2'h0;
          if (wr_fire)
          begin
            case (apb_paddr_in)
              `CRR_OFF_INSTR:
              begin
                opcode <= apb_pwdata_in[15:0];
                state <= ST_EXEC;
              end
              `CRR_OFF_CTRL:
              begin
                ext_en <= apb_pwdata_in[`CRR_CTL_EXT];
                gie_high <= apb_pwdata_in[`CRR_CTL_HIGH_PRIORITY_GLOBAL_IRQ_ENABLE];
                gie_low <= apb_pwdata_in[`CRR_CTL_LOW_PRIORITY_GLOBAL_IRQ_ENABLE];
              end
              `CRR_OFF_PC: pc <= apb_pwdata_in[20:0];
              `CRR_OFF_ACC: acc <= apb_pwdata_in[7:0];
              `CRR_OFF_FLAGS: flags <= apb_pwdata_in[7:0];
              `CRR_OFF_BANK: bank <= apb_pwdata_in[3:0];
              `CRR_OFF_SHADOW:
              begin
                acc_shadow <= apb_pwdata_in[7:0];
                flags_shadow <= apb_pwdata_in[`CRR_SHD_FLAGS +: 8];
                bank_shadow <= apb_pwdata_in[`CRR_SHD_BANK +: 4];
              end
              `CRR_OFF_MADDR: mem_addr <= apb_pwdata_in[11:0];
              `CRR_OFF_INDEX: index_base <= apb_pwdata_in[11:0];
              `CRR_OFF_LATCH:
              begin
                latch_high <= apb_pwdata_in[7:0];
                latch_upper <= apb_pwdata_in[15:8];
              end
              default: state <= ST_IDLE;
            endcase
          end
        end
        ST_EXEC:
        begin
          quarter <= quarter + 2'h1;
          case (quarter)
            2'h0: op_addr <= eff_addr(opcode[7:0], opcode[`CRR_BIT_A], bank, ext_en,
                                      index_base);
            2'h1:
            begin
              operand <= dmem[op_addr];
              if (push_now)
                sp <= sp + 5'h1;
              if (is_swrst)
                arch_clear;
            end
            2'h2: operand <= operand;
            default:
            begin
              state <= two_cycle ? ST_WAIT : ST_IDLE;
              if (is_relative_call)
                pc <= call_target;
              else if (is_pop)
              begin
                pc <= stack_top;
                if (sp != 5'h0)
                  sp <= sp - 5'h1;
              end
              else if (!is_swrst)
                pc <= pc_next;
              if (is_reti)
              begin
                if (gie_high)
                  gie_low <= 1'b1;
                else
                  gie_high <= 1'b1;
              end
              if ((is_reti || is_ret) && opcode[0])
              begin
                acc <= acc_shadow;
                flags <= flags_shadow;
                bank <= bank_shadow;
              end
              if (is_return_with_literal)
                acc <= opcode[7:0];
              if (is_rot)
              begin
                if (!opcode[`CRR_BIT_D])
                  acc <= rot_res;
                flags[`CRR_FLG_N] <= rot_res[7];
                flags[`CRR_FLG_Z] <= (rot_res == 8'h00);
                if (!is_rlnc)
                  flags[`CRR_FLG_C] <= rot_carry;
              end
            end
          endcase
        end
        ST_WAIT:
        begin
          quarter <= quarter + 2'h1;
          if (quarter == `CRR_Q_LAST)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // read mux and address check
  always @*
  begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    case (apb_paddr_in)
      `CRR_OFF_INSTR:
      begin
        next_rdata[15:0] = opcode;
        next_rdata[`CRR_INS_BUSY] = !idle;
      end
      `CRR_OFF_CTRL: next_rdata = {29'h00000000, gie_low, gie_high, ext_en};
      `CRR_OFF_PC: next_rdata = {11'h000, pc};
      `CRR_OFF_ACC: next_rdata = {24'h000000, acc};
      `CRR_OFF_FLAGS: next_rdata = {24'h000000, flags};
      `CRR_OFF_BANK: next_rdata = {28'h0000000, bank};
      `CRR_OFF_SHADOW:
      begin
        next_rdata[7:0] = acc_shadow;
        next_rdata[`CRR_SHD_FLAGS +: 8] = flags_shadow;
        next_rdata[`CRR_SHD_BANK +: 4] = bank_shadow;
      end
      `CRR_OFF_STACK:
      begin
        next_rdata[20:0] = stack_top;
        next_rdata[`CRR_STK_PTR +: 5] = sp;
      end
      `CRR_OFF_MADDR: next_rdata = {20'h00000, mem_addr};
      `CRR_OFF_MDATA: next_rdata = {24'h000000, dmem[mem_addr]};
      `CRR_OFF_INDEX: next_rdata = {20'h00000, index_base};
      `CRR_OFF_LATCH: next_rdata = {16'h0000, latch_upper, latch_high};
      default: next_err = 1'b1;
    endcase
  end

  // apb answer one cycle into the access phase
  always @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      apb_pready_out <= 1'b0;
      apb_prdata_out <= 32'h00000000;
      apb_pslverr_out <= 1'b0;
    end
    else
    begin
      apb_pready_out <= acc_first;
      apb_pslverr_out <= acc_first && next_err;
      if (acc_first && !apb_pwrite_in)
        apb_prdata_out <= next_rdata;
    end
  end
endmodule // crr_exec_core

// ===== hw/crr_exec_consts.vh
// constants for the call, return and rotate execution slice
`ifndef CRR_EXEC_CONSTS_VH
`define CRR_EXEC_CONSTS_VH
`define CRR_OFF_INSTR 12'h000
`define CRR_OFF_CTRL 12'h004
`define CRR_OFF_PC 12'h008
`define CRR_OFF_ACC 12'h00C
`define CRR_OFF_FLAGS 12'h010
`define CRR_OFF_BANK 12'h014
`define CRR_OFF_SHADOW 12'h018
`define CRR_OFF_STACK 12'h01C
`define CRR_OFF_MADDR 12'h020
`define CRR_OFF_MDATA 12'h024
`define CRR_OFF_INDEX 12'h028
`define CRR_OFF_LATCH 12'h02C
`define CRR_FLG_C 0
`define CRR_FLG_Z 2
`define CRR_FLG_N 4
`define CRR_CTL_EXT 0
`define CRR_CTL_HIGH_PRIORITY_GLOBAL_IRQ_ENABLE 1
`define CRR_CTL_LOW_PRIORITY_GLOBAL_IRQ_ENABLE 2
`define CRR_INS_BUSY 16
`define CRR_RST_PC 21'h000000
`define CRR_RST_BYTE 8'h00
`define CRR_RST_BANK 4'h0
`define CRR_RST_ADDR 12'h000
`define CRR_OP_PUSH 16'h0005
`define CRR_OP_SWRST 16'h00FF
`define CRR_OP_RETI 15'h0008
`define CRR_OP_RET 15'h0009
`define CRR_OP_RETURN_WITH_LITERAL 8'h0C
`define CRR_OP_RELATIVE_CALL 5'h1B
`define CRR_OP_RLC 6'h0D
`define CRR_OP_RLNC 6'h11
`define CRR_OP_RRC 6'h0C
`define CRR_BIT_D 9
`define CRR_BIT_A 8
`define CRR_SHD_FLAGS 8
`define CRR_SHD_BANK 16
`define CRR_STK_PTR 24
`define CRR_LIT_MAX 8'h5F
`define CRR_ACC_SPLIT 8'h60
`define CRR_PC_STEP 21'h000002
`define CRR_STK_FULL 5'h1F
`define CRR_Q_LAST 2'h3
`endif

// ===== sim/crr_exec_sva.sv
// apb handshake checks for the execution slice
`timescale 1ns/1ps
module crr_exec_sva (
  input wire ref_clk_in,
  input wire sys_rst_in,
  input wire apb_psel_in,
  input wire apb_penable_in,
  input wire apb_pwrite_in,
  input wire [11:0] apb_paddr_in,
  input wire [31:0] apb_prdata_out,
  input wire apb_pready_out,
  input wire apb_pslverr_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  // first access cycle of a transfer
  sequence acc_start;
    apb_psel_in && apb_penable_in && !$past(apb_penable_in);
  endsequence
  // one wait state, then the answer
  sequence answer;
    !apb_pready_out ##1 apb_pready_out;
  endsequence
  a_ready_latency: assert property (acc_start |-> answer) else $error("late ready");
  a_ready_access: assert property (apb_pready_out |-> apb_psel_in && apb_penable_in)
    else $error("ready outside access");
  a_ready_pulse: assert property (apb_pready_out |=> !apb_pready_out) else $error("ready held");
  a_err_ready: assert property (apb_pslverr_out |-> apb_pready_out) else $error("stray error");
  a_err_unmapped: assert property (apb_pready_out
    && (apb_paddr_in > 12'h02C || apb_paddr_in[1:0] != 2'h0) |-> apb_pslverr_out)
    else $error("unmapped not flagged");
  a_err_mapped: assert property (apb_pready_out
    && apb_paddr_in < 12'h030 && apb_paddr_in[1:0] == 2'h0 |-> !apb_pslverr_out)
    else $error("mapped flagged");
  a_err_zero_read: assert property (apb_pslverr_out && !apb_pwrite_in |-> apb_prdata_out == 32'h0)
    else $error("error read not zero");
  a_rdata_holds: assert property (!$stable(apb_prdata_out) |-> apb_pready_out && !apb_pwrite_in)
    else $error("read data moved");
endmodule // crr_exec_sva
bind crr_exec_core crr_exec_sva chk (.ref_clk_in, .sys_rst_in, .apb_psel_in, .apb_penable_in,
  .apb_pwrite_in, .apb_paddr_in, .apb_prdata_out, .apb_pready_out, .apb_pslverr_out);

// ===== sim/crr_fetch_model.sv
// opcode source standing in for instruction fetch
`timescale 1ns/1ps
module crr_fetch_model (
  input wire [3:0] idx_in,
  output logic [15:0] op_out
);
  always_comb
  begin
    case (idx_in)
      4'h0: op_out = 16'h0005;
      4'h1: op_out = 16'hDFFF;
      4'h2: op_out = 16'hDBFF;
      4'h3: op_out = 16'h0013;
      4'h4: op_out = 16'h0010;
      4'h5: op_out = 16'h0CAB;
      4'h6: op_out = 16'h3510;
      4'h7: op_out = 16'h4710;
      4'h8: op_out = 16'h3205;
      default: op_out = 16'h00FF;
    endcase
  end
endmodule // crr_fetch_model

// ===== sim/call_return_rotate_exec_tb.sv
// self-checking bench for the call, return and rotate slice
`timescale 1ns/1ps
module call_return_rotate_exec_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic [31:0] rdv;
  logic prdy;
  logic perr;
  logic errv;
  logic [3:0] idx = 4'h0;
  logic [15:0] op;
  int miscompares = 0;
  int checks = 0;
  always #5 clk = ~clk;
  crr_exec_core uut (.ref_clk_in(clk), .sys_rst_in(rst), .apb_psel_in(psel),
    .apb_penable_in(pen), .apb_pwrite_in(pwr), .apb_paddr_in(pa), .apb_pwdata_in(pwd),
    .apb_prdata_out(prd), .apb_pready_out(prdy), .apb_pslverr_out(perr));
  crr_fetch_model fetch (.idx_in(idx), .op_out(op));
  task give_verdict;
    if (miscompares == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until ready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (prdy !== 1'b1 && n < 20);
    if (prdy !== 1'b1)
    begin
      miscompares++;
      give_verdict;
    end
    rdv = prd;
    errv = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task rc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask
  // issue one opcode and poll busy
  task run(input logic [3:0] i);
    int n;
    n = 0;
    idx <= i;
    @(posedge clk);
    apb(1'b1, 12'h000, {16'h0, op});
    do
    begin
      apb(1'b0, 12'h000, 32'h0);
      n++;
    end
    while (rdv[16] !== 1'b0 && n < 20);
    if (rdv[16] !== 1'b0)
    begin
      miscompares++;
      give_verdict;
    end
  endtask
  task t_call;
    apb(1'b1, 12'h008, 32'h100);
    apb(1'b1, 12'h010, 32'h15);
    run(4'h0);
    rc(12'h01C, 32'h01000102);
    rc(12'h008, 32'h102);
    run(4'h1);
    rc(12'h008, 32'h102);
    rc(12'h01C, 32'h02000104);
    run(4'h2);
    rc(12'h008, 32'h902);
    rc(12'h010, 32'h15);
  endtask
  task t_ret;
    apb(1'b1, 12'h018, 32'h0005043C);
    run(4'h3);
    rc(12'h008, 32'h104);
    rc(12'h00C, 32'h3C);
    rc(12'h010, 32'h04);
    rc(12'h014, 32'h5);
    apb(1'b1, 12'h00C, 32'h77);
    run(4'h4);
    rc(12'h00C, 32'h77);
    rc(12'h004, 32'h2);
    rc(12'h01C, 32'h01000102);
    apb(1'b1, 12'h02C, 32'h1234);
    run(4'h5);
    rc(12'h00C, 32'hAB);
    rc(12'h008, 32'h102);
    rc(12'h02C, 32'h1234);
    rc(12'h01C, 32'h0);
  endtask
  task t_rot;
    apb(1'b1, 12'h014, 32'h2);
    apb(1'b1, 12'h020, 32'h210);
    apb(1'b1, 12'h024, 32'hE6);
    apb(1'b1, 12'h010, 32'h0);
    run(4'h6);
    rc(12'h00C, 32'hCC);
    rc(12'h010, 32'h11);
    rc(12'h024, 32'hE6);
    run(4'h7);
    rc(12'h024, 32'hCD);
    rc(12'h00C, 32'hCC);
    rc(12'h010, 32'h11);
    apb(1'b1, 12'h004, 32'h1);
    apb(1'b1, 12'h028, 32'h300);
    apb(1'b1, 12'h020, 32'h305);
    apb(1'b1, 12'h024, 32'h1);
    apb(1'b1, 12'h010, 32'h0);
    run(4'h8);
    rc(12'h024, 32'h0);
    rc(12'h010, 32'h05);
  endtask
  task t_rst;
    run(4'h9);
    rc(12'h008, 32'h0);
    rc(12'h00C, 32'h0);
    rc(12'h014, 32'h0);
    rc(12'h004, 32'h0);
    rc(12'h010, 32'h0);
    rc(12'h01C, 32'h0);
    apb(1'b0, 12'h030, 32'h0);
    chk({31'h0, errv}, 32'h1);
    chk(rdv, 32'h0);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_call;
    t_ret;
    t_rot;
    t_rst;
    give_verdict;
  end
endmodule // call_return_rotate_exec_tb
